// [hw/cfs_freq_select.sv]
// CPU clock frequency source selection with watchdog recovery
`timescale 1ns/1ps
`include "cfs_params.svh"
module cfs_freq_select #(
    parameter int unsigned WD_TIMEOUT_CYC = `CFS_WD_TIMEOUT_US * `CFS_CLK_MHZ
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [4:0] strap_frequency_code,
    input wire logic cfg_wr,
    input cfs_pkg::cfs_ctrl_t cfg_wdata,
    input wire logic status_wr,
    input wire logic status_wdata,
    output cfs_pkg::cfs_ctrl_t ctrl_readback,
    output logic [4:0] strap_code_latched,
    output logic watchdog_expired_flag,
    output logic sys_reset_b,
    output logic freq_load,
    output cfs_pkg::cfs_freq_t freq_out
);

    localparam logic [31:0] WD_RELOAD = 32'(WD_TIMEOUT_CYC);
    localparam logic [7:0] SYSRST_CYC = 8'(`CFS_SYSRST_CYC);

    typedef struct packed {
        logic [4:0] strap_s1;
        logic [4:0] strap_s2;
        logic strap_taken;
        logic [4:0] strap_code;
        cfs_pkg::cfs_ctrl_t ctrl;
        logic [31:0] wd_count;
        logic wd_running;
        logic expired;
        logic recovery;
        logic [7:0] rst_count;
        logic sys_reset_b;
        logic load;
        cfs_pkg::cfs_freq_t freq;
    } cfs_state_t;

    cfs_state_t st_reg;
    cfs_state_t st_next;
    cfs_pkg::cfs_rates_t table_rates;
    logic [4:0] table_code;
    logic [4:0] ratio_code;
    logic wd_fire;

    assign ratio_code = st_reg.ctrl.select_override ? st_reg.ctrl.soft_code
                                                    : st_reg.strap_code;
    assign wd_fire = st_reg.wd_running && st_reg.ctrl.watchdog_arm && (st_reg.wd_count == 32'h1);

    cfs_rate_table u_rate_table (
        .code(table_code),
        .rates(table_rates)
    );

    always_comb
    begin
        st_next = st_reg;
        st_next.load = 1'b0;
        // Strap pins pass two flops, then are caught once
        st_next.strap_s1 = strap_frequency_code;
        st_next.strap_s2 = st_reg.strap_s1;
        if (!st_reg.strap_taken)
        begin
            st_next.strap_code = st_reg.strap_s2;
            st_next.strap_taken = 1'b1;
        end
        if (cfg_wr)
        begin
            st_next.ctrl = cfg_wdata;
            st_next.load = 1'b1;
            st_next.recovery = 1'b0;
        end
        // Watchdog
        if (!st_reg.ctrl.watchdog_arm)
        begin
            st_next.wd_count = WD_RELOAD;
            st_next.wd_running = 1'b0;
        end
        else if (st_reg.load && !st_reg.recovery)
        begin
            st_next.wd_count = WD_RELOAD;
            st_next.wd_running = 1'b1;
        end
        else if (wd_fire)
        begin
            st_next.wd_running = 1'b0;
            st_next.recovery = 1'b1;
            st_next.load = 1'b1;
            st_next.rst_count = SYSRST_CYC;
        end
        else if (st_reg.wd_running)
        begin
            st_next.wd_count = st_reg.wd_count - 32'h1;
        end
        // Expired flag: a new expiry wins over a clear in the same cycle
        if (status_wr && status_wdata)
        begin
            st_next.expired = 1'b0;
        end
        if (wd_fire)
        begin
            st_next.expired = 1'b1;
        end
        // System reset pulse
        if (st_reg.rst_count != 8'h0 && !wd_fire)
        begin
            st_next.rst_count = st_reg.rst_count - 8'h1;
        end
        st_next.sys_reset_b = (st_next.rst_count == 8'h0);
        // Frequency source
        table_code = ratio_code;
        st_next.freq.sel_code = ratio_code;
        st_next.freq.use_divider = 1'b0;
        st_next.freq.feedback_count = st_reg.ctrl.cpu_feedback_count;
        st_next.freq.reference_count = st_reg.ctrl.cpu_reference_count;
        if (st_reg.recovery)
        begin
            if (st_reg.ctrl.recovery_source_select)
            begin
                st_next.freq.use_divider = 1'b1;
                st_next.freq.feedback_count = st_reg.ctrl.recovery_feedback_count;
                st_next.freq.reference_count = st_reg.ctrl.recovery_reference_count;
            end
            else
            begin
                table_code = st_reg.strap_code;
                st_next.freq.sel_code = st_reg.strap_code;
            end
        end
        else if (st_reg.ctrl.prog_enable)
        begin
            st_next.freq.use_divider = 1'b1;
        end
        st_next.freq.rates = table_rates;
        if (st_next.freq.use_divider)
        begin
            st_next.freq.rates.cpu_hz = 28'h0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            st_reg <= '0;
            st_reg.ctrl.prog_enable <= `CFS_PROG_ENABLE_RST;
            st_reg.ctrl.select_override <= `CFS_OVERRIDE_RST;
            st_reg.ctrl.watchdog_arm <= `CFS_WD_ARM_RST;
            st_reg.wd_count <= WD_RELOAD;
            st_reg.sys_reset_b <= 1'b1;
            // Strap synchroniser runs through reset so the code is settled at release
            st_reg.strap_s1 <= st_next.strap_s1;
            st_reg.strap_s2 <= st_next.strap_s2;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign ctrl_readback = st_reg.ctrl;
    assign strap_code_latched = st_reg.strap_code;
    assign watchdog_expired_flag = st_reg.expired;
    assign sys_reset_b = st_reg.sys_reset_b;
    assign freq_load = st_reg.load;
    assign freq_out = st_reg.freq;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    a_prog_reset_off: assert property ($past(!rst_b) |-> !st_reg.ctrl.prog_enable)
        else $error("prog enable not clear after reset");
    a_strap_held: assert property (st_reg.strap_taken |=> $stable(st_reg.strap_code))
        else $error("latched strap code changed");
    a_strap_mode: assert property (!st_reg.recovery && !st_reg.ctrl.prog_enable
        && !st_reg.ctrl.select_override |=> !freq_out.use_divider
        && freq_out.sel_code == $past(st_reg.strap_code))
        else $error("strap mode not taken");
    a_soft_mode: assert property (!st_reg.recovery && !st_reg.ctrl.prog_enable
        && st_reg.ctrl.select_override |=> !freq_out.use_divider
        && freq_out.sel_code == $past(st_reg.ctrl.soft_code))
        else $error("software code not taken");
    a_divider_mode: assert property (!st_reg.recovery && st_reg.ctrl.prog_enable
        |=> freq_out.use_divider
        && freq_out.feedback_count == $past(st_reg.ctrl.cpu_feedback_count)
        && freq_out.reference_count == $past(st_reg.ctrl.cpu_reference_count))
        else $error("divider counts not used");
    a_gear_ratio: assert property (!st_reg.recovery |=> freq_out.sel_code == $past(ratio_code))
        else $error("gear code wrong");
    a_code_200: assert property (freq_out.sel_code == `CFS_CODE_20000 && !freq_out.use_divider
        |-> freq_out.rates.cpu_hz == `CFS_HZ_200M0
        && freq_out.rates.fixed_hz == `CFS_HZ_48M007)
        else $error("code 11110 rate wrong");
    a_code_133: assert property (freq_out.sel_code == `CFS_CODE_13330 && !freq_out.use_divider
        |-> freq_out.rates.cpu_hz == `CFS_HZ_133M3
        && freq_out.rates.pci_hz == `CFS_HZ_33M3)
        else $error("code 11111 rate wrong");
    a_expiry_reset: assert property (wd_fire |=> !sys_reset_b && st_reg.recovery
        && watchdog_expired_flag ##1 !sys_reset_b)
        else $error("expiry did not reset and recover");
    a_recovery_counts: assert property (st_reg.recovery && st_reg.ctrl.recovery_source_select
        |=> freq_out.use_divider
        && freq_out.feedback_count == $past(st_reg.ctrl.recovery_feedback_count))
        else $error("recovery counts not used");
    a_write_load: assert property (cfg_wr |=> freq_load
        && ctrl_readback.cpu_feedback_count == $past(cfg_wdata.cpu_feedback_count))
        else $error("count write did not load");
    a_wd_disarm: assert property (!st_reg.ctrl.watchdog_arm |=> !st_reg.wd_running
        && st_reg.wd_count == WD_RELOAD)
        else $error("watchdog not stopped");
    a_flag_clear: assert property (watchdog_expired_flag && status_wr && status_wdata && !wd_fire
        |=> !watchdog_expired_flag)
        else $error("expired flag not cleared");

    c_expiry: cover property (wd_fire);
    c_divider: cover property (freq_out.use_divider && !st_reg.recovery);
    c_override: cover property (st_reg.ctrl.select_override && !st_reg.ctrl.prog_enable);
    c_clear_race: cover property (wd_fire && status_wr && status_wdata);

endmodule : cfs_freq_select

// [hw/cfs_params.svh]
// Offsets-free constants: reset values, select codes, table entries and timing for the selector
`ifndef CFS_PARAMS_SVH
`define CFS_PARAMS_SVH

`define CFS_CLK_MHZ 125
`define CFS_WD_TIMEOUT_US 1000
`define CFS_SYSRST_NS 1000
`define CFS_SYSRST_CYC ((`CFS_SYSRST_NS * `CFS_CLK_MHZ + 999) / 1000)

`define CFS_PROG_ENABLE_RST 1'h0
`define CFS_OVERRIDE_RST 1'h0
`define CFS_WD_ARM_RST 1'h0

`define CFS_CODE_6666 5'h1c
`define CFS_CODE_10000 5'h1d
`define CFS_CODE_20000 5'h1e
`define CFS_CODE_13330 5'h1f

`define CFS_HZ_66M6 28'h3f83c40
`define CFS_HZ_100M0 28'h5f5e100
`define CFS_HZ_200M0 28'hbebc200
`define CFS_HZ_133M3 28'h7f1ff20
`define CFS_HZ_33M3 28'h1fc1e20
`define CFS_HZ_48M007 28'h2dc88f2

`endif

// [hw/cfs_pkg.sv]
// Types shared by the frequency selector and its rate table
package cfs_pkg;

    typedef struct packed {
        logic prog_enable;
        logic select_override;
        logic [4:0] soft_code;
        logic [7:0] cpu_feedback_count;
        logic [6:0] cpu_reference_count;
        logic recovery_source_select;
        logic [7:0] recovery_feedback_count;
        logic [6:0] recovery_reference_count;
        logic watchdog_arm;
    } cfs_ctrl_t;

    typedef struct packed {
        logic [27:0] cpu_hz;
        logic [27:0] mid_hz;
        logic [27:0] pci_hz;
        logic [27:0] fixed_hz;
    } cfs_rates_t;

    typedef struct packed {
        logic use_divider;
        logic [7:0] feedback_count;
        logic [6:0] reference_count;
        logic [4:0] sel_code;
        cfs_rates_t rates;
    } cfs_freq_t;

endpackage : cfs_pkg

// [hw/cfs_rate_table.sv]
// Nominal output rates for the select codes that the selector knows
`timescale 1ns/1ps
`include "cfs_params.svh"
module cfs_rate_table (
    input wire logic [4:0] code,
    output cfs_pkg::cfs_rates_t rates
);

    always_comb
    begin
        rates.mid_hz = `CFS_HZ_66M6;
        rates.pci_hz = `CFS_HZ_33M3;
        rates.fixed_hz = `CFS_HZ_48M007;
        case (code)
            `CFS_CODE_6666: rates.cpu_hz = `CFS_HZ_66M6;
            `CFS_CODE_10000: rates.cpu_hz = `CFS_HZ_100M0;
            `CFS_CODE_20000: rates.cpu_hz = `CFS_HZ_200M0;
            `CFS_CODE_13330: rates.cpu_hz = `CFS_HZ_133M3;
            default:
            begin
                // Codes outside the known rows report no rate
                rates.cpu_hz = 28'h0;
                rates.mid_hz = 28'h0;
                rates.pci_hz = 28'h0;
                rates.fixed_hz = 28'h0;
            end
        endcase
    end

endmodule : cfs_rate_table

// [tb/cfs_host_model.sv]
// Host model that issues control and status writes to the selector
`timescale 1ns/1ps
module cfs_host_model (
    input wire logic core_clk,
    output logic cfg_wr,
    output cfs_pkg::cfs_ctrl_t cfg_wdata,
    output logic status_wr,
    output logic status_wdata
);
    initial
    begin
        cfg_wr = 1'h0;
        cfg_wdata = '0;
        status_wr = 1'h0;
        status_wdata = 1'h0;
    end
    // Whole control set in one write, so both CPU counts change together
    task automatic write_cfg(input cfs_pkg::cfs_ctrl_t value);
        @(posedge core_clk);
        #1;
        cfg_wr = 1'h1;
        cfg_wdata = value;
        @(posedge core_clk);
        #1;
        cfg_wr = 1'h0;
        cfg_wdata = ~value;
    endtask : write_cfg
    task automatic write_status(input logic value);
        @(posedge core_clk);
        #1;
        status_wr = 1'h1;
        status_wdata = value;
        @(posedge core_clk);
        #1;
        status_wr = 1'h0;
        status_wdata = ~value;
    endtask : write_status
endmodule : cfs_host_model

// [tb/testbench.sv]
// Self-checking bench for the frequency selector
`timescale 1ns/1ps
`include "cfs_params.svh"
module testbench;
    localparam int WD = 20;
    logic core_clk = 1'h0;
    logic rst_b = 1'h0;
    logic [4:0] strap = 5'h1e;
    logic [4:0] strap_ref = 5'h1e;
    int seed = 32'h643d0db3;
    int n_fail = 0;
    int compares = 0;
    int n;
    logic cfg_wr, status_wr, status_wdata, flag, srst_b, load;
    cfs_pkg::cfs_ctrl_t cfg_wdata, rb, c;
    cfs_pkg::cfs_freq_t fo;
    logic [4:0] latched;
    logic [4:0] codes [5] = '{5'h1c, 5'h1d, 5'h1e, 5'h1f, 5'h0b};
    cfs_host_model i_host (.core_clk(core_clk), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
        .status_wr(status_wr), .status_wdata(status_wdata));
    cfs_freq_select #(.WD_TIMEOUT_CYC(WD)) i_dut (.core_clk(core_clk), .rst_b(rst_b),
        .strap_frequency_code(strap), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
        .status_wr(status_wr), .status_wdata(status_wdata), .ctrl_readback(rb),
        .strap_code_latched(latched), .watchdog_expired_flag(flag),
        .sys_reset_b(srst_b), .freq_load(load), .freq_out(fo));
    initial
    begin
        forever #4 core_clk = ~core_clk;
    end
    task automatic finish_test;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test
    task automatic cmp(input logic [127:0] got, input logic [127:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    function automatic cfs_pkg::cfs_freq_t exp_freq(input cfs_pkg::cfs_ctrl_t k, input bit rec);
        cfs_pkg::cfs_freq_t f;
        f = '0;
        f.sel_code = k.select_override ? k.soft_code : strap_ref;
        f.use_divider = k.prog_enable;
        f.feedback_count = k.cpu_feedback_count;
        f.reference_count = k.cpu_reference_count;
        if (rec)
        begin
            f.use_divider = k.recovery_source_select;
            f.feedback_count = k.recovery_feedback_count;
            f.reference_count = k.recovery_reference_count;
            if (!k.recovery_source_select)
                f.sel_code = strap_ref;
        end
        if (f.sel_code[4:2] == 3'h7)
            f.rates = {28'h0, 28'(`CFS_HZ_66M6), 28'(`CFS_HZ_33M3), 28'(`CFS_HZ_48M007)};
        case (f.sel_code)
            5'h1c: f.rates.cpu_hz = `CFS_HZ_66M6;
            5'h1d: f.rates.cpu_hz = `CFS_HZ_100M0;
            5'h1e: f.rates.cpu_hz = `CFS_HZ_200M0;
            5'h1f: f.rates.cpu_hz = `CFS_HZ_133M3;
            default: ;
        endcase
        if (f.use_divider)
            f.rates.cpu_hz = '0;
        return f;
    endfunction : exp_freq
    task automatic check_freq(input cfs_pkg::cfs_freq_t f);
        cmp(128'({fo.use_divider, fo.sel_code, fo.rates}),
            128'({f.use_divider, f.sel_code, f.rates}));
        if (f.use_divider)
            cmp(128'({fo.feedback_count, fo.reference_count}),
                128'({f.feedback_count, f.reference_count}));
    endtask : check_freq
    task automatic do_cfg(input cfs_pkg::cfs_ctrl_t k);
        i_host.write_cfg(k);
        cmp(128'(rb), 128'(k));
        cmp(128'(load), 128'h1);
        @(posedge core_clk);
        #1;
        cmp(128'(load), 128'h0);
        check_freq(exp_freq(k, 1'b0));
    endtask : do_cfg
    initial
    begin
        repeat (20) @(posedge core_clk);
        #1;
        rst_b = 1'h1;
        repeat (3) @(posedge core_clk);
        #1;
        cmp(128'({rb, flag, srst_b}), 128'h1);
        cmp(128'(latched), 128'h1e);
        check_freq(exp_freq('0, 1'b0));
        strap = 5'h03;
        c = '0;
        c.select_override = 1'h1;
        for (int i = 0; i < 5; i++)
        begin
            c.soft_code = codes[i];
            do_cfg(c);
        end
        repeat (4)
        begin
            c = 46'($random(seed) ^ ({$random(seed)} << 20));
            c.prog_enable = 1'h1;
            c.watchdog_arm = 1'h0;
            do_cfg(c);
        end
        for (int src = 0; src < 2; src++)
        begin
            c = 46'($random(seed) ^ ({$random(seed)} << 20));
            c.prog_enable = 1'h1;
            c.watchdog_arm = 1'h1;
            c.recovery_source_select = src[0];
            do_cfg(c);
            n = 0;
            while (srst_b !== 1'b0 && n < 200)
            begin
                @(posedge core_clk);
                #1;
                n++;
            end
            if (n >= 200)
            begin
                n_fail++;
                finish_test();
            end
            cmp(128'(n >= WD - 3 && n <= WD + 3), 128'h1);
            cmp(128'({flag, load}), 128'h3);
            n = 1;
            @(posedge core_clk);
            #1;
            check_freq(exp_freq(c, 1'b1));
            while (srst_b === 1'b0 && n < 300)
            begin
                n++;
                @(posedge core_clk);
                #1;
            end
            cmp(128'(n), 128'(`CFS_SYSRST_CYC));
            i_host.write_status(1'h0);
            cmp(128'(flag), 128'h1);
            i_host.write_status(1'h1);
            cmp(128'(flag), 128'h0);
            c.watchdog_arm = 1'h0;
            do_cfg(c);
            n = 0;
            repeat (3 * WD)
            begin
                @(posedge core_clk);
                #1;
                n += (srst_b !== 1'b1);
            end
            cmp(128'({n, flag}), 128'h0);
        end
        cmp(128'(latched), 128'h1e);
        // Second reset with new strap pins: the code is caught again
        rst_b = 1'h0;
        strap = 5'h1d;
        strap_ref = 5'h1d;
        repeat (4) @(posedge core_clk);
        #1;
        rst_b = 1'h1;
        repeat (3) @(posedge core_clk);
        #1;
        cmp(128'({rb, flag, srst_b}), 128'h1);
        cmp(128'(latched), 128'h1d);
        check_freq(exp_freq('0, 1'b0));
        finish_test();
    end
endmodule : testbench
